// file: core/amp_pkg.sv
// shared constants and types of the mode programming port
package amp_pkg;

   // frame layout: bit 15 read flag, bits 14:8 address, bits 7:0 data, msb first
   localparam int          FRAME_BITS     = 16;
   localparam int          ADDR_W         = 7;
   localparam int          DATA_W         = 8;
   localparam logic [4:0]  CNT_CMD_LAST   = 5'h07;
   localparam logic [4:0]  CNT_FRAME_LAST = 5'h0F;
   localparam logic [4:0]  CNT_DRV_FIRST  = 5'h08;
   localparam logic [4:0]  CNT_SMP_FIRST  = 5'h09;
   localparam logic [4:0]  CNT_FRAME_END  = 5'h10;

   // control register of the converter and its fields
   localparam logic [6:0]  REG_CTRL       = 7'h00;
   localparam int          CTRL_PD_BIT    = 0;
   localparam int          CTRL_ONE_BIT   = 1;
   localparam int          CTRL_HALF_BIT  = 2;
   localparam int          CTRL_TERM_BIT  = 3;
   localparam logic [7:0]  REG_RESET      = 8'h00;

   // host register map, byte addresses
   localparam logic [3:0]  HOST_CMD       = 4'h0;
   localparam logic [3:0]  HOST_STAT      = 4'h4;
   localparam logic [3:0]  HOST_RDATA     = 4'h8;
   localparam logic [3:0]  HOST_PAR       = 4'hC;
   localparam int          STAT_BUSY_BIT  = 0;
   localparam int          STAT_DONE_BIT  = 1;
   localparam int          PAR_EN_BIT     = 4;

   // link timing
   localparam int          SYS_PERIOD_NS  = 40;
   localparam int          SCK_READ_NS    = 250;
   localparam int          CS_SETUP_NS    = 5;
   localparam int          SCK_HALF_CYC   = (SCK_READ_NS + 2 * SYS_PERIOD_NS - 1)
                                            / (2 * SYS_PERIOD_NS);
   localparam int          CS_SETUP_CYC   = (CS_SETUP_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
   localparam int          DIV_W          = 4;

   typedef enum logic [1:0] {
      D_IDLE  = 2'b00,
      D_SHIFT = 2'b01,
      D_DONE  = 2'b10
   } amp_dst_type;

   typedef enum logic [2:0] {
      H_IDLE  = 3'b000,
      H_SETUP = 3'b001,
      H_LOW   = 3'b010,
      H_HIGH  = 3'b011,
      H_HOLD  = 3'b100
   } amp_hst_type;

endpackage

// file: core/amp_if.sv
// pins between the host controller and the converter's programming port
`timescale 1ns/100ps
interface amp_if;
   logic csN;
   logic sck;
   logic sdi;
   logic strap;
   logic devSdoOut;
   logic devSdoOe;
   logic hostSdoOut;
   logic hostSdoOe;
   logic sdo;

   // open-drain line with board pull-up; host drives it only as a static level
   assign sdo = hostSdoOe ? hostSdoOut : !(devSdoOe && !devSdoOut);

   modport dev (
      input  csN,
      input  sck,
      input  sdi,
      input  sdo,
      input  strap,
      output devSdoOut,
      output devSdoOe
   );

   modport host (
      output csN,
      output sck,
      output sdi,
      output hostSdoOut,
      output hostSdoOe,
      input  sdo
   );
endinterface

// file: core/amp_dev.sv
// converter end of the mode programming port
// Behaviour
// - strap low: pins form serial register port
// - strap high: pins are static mode levels
// - board ties strap fixed, never toggled; the bench toggles it in t_parallel
// - shift only while chip select low
// - sample data in on clock rising
// - host captures readback on clock falling
// - readback output only pulls low
// - parallel: chip select picks lane count
// - parallel: clock pin picks drive current
// - parallel: data in pin powers down
// - parallel: data out pin enables termination
// - one-lane mode disables secondary lanes
// - configurator keeps serial rate in limit
`timescale 1ns/100ps
module amp_dev #(
   parameter int NUM_REGS = 5
) (
   input  wire logic                                  clk_sys,
   input  wire logic                                  rst,
   input  wire logic                                  ce,
   amp_if.dev                                         link,
   output logic                                       serialMode,
   output logic                                       powerDown,
   output logic                                       oneLane,
   output logic                                       laneBEnable,
   output logic                                       halfCurrent,
   output logic                                       termEnable,
   output logic [NUM_REGS-1:0][amp_pkg::DATA_W-1:0]   regFile
);

   typedef struct packed {
      logic [1:0]                                     csS;
      logic [2:0]                                     sckS;
      logic [1:0]                                     sdiS;
      logic [1:0]                                     sdoS;
      logic [1:0]                                     strapS;
      amp_pkg::amp_dst_type                           state;
      logic [4:0]                                     bitCnt;
      logic [amp_pkg::FRAME_BITS-1:0]                 shift;
      logic                                           rdMode;
      logic [amp_pkg::DATA_W-1:0]                     rdSh;
      logic                                           sdoDrive;
      logic                                           pd;
      logic                                           one;
      logic                                           half;
      logic                                           term;
      logic [NUM_REGS-1:0][amp_pkg::DATA_W-1:0]       regs;
   } amp_dstate_type;

   amp_dstate_type                                    q;
   amp_dstate_type                                    d;

   logic                                              isSerial;
   logic                                              csLevel;
   logic                                              sckRise;
   logic                                              sckFall;
   logic [amp_pkg::DATA_W-1:0]                        cmdByte;
   logic [amp_pkg::FRAME_BITS-1:0]                    frameWord;
   logic [amp_pkg::ADDR_W-1:0]                        frameAddr;
   logic [amp_pkg::DATA_W-1:0]                        frameData;
   logic [amp_pkg::DATA_W-1:0]                        ctrlReg;

   // address decode shared by register read and write
   function automatic logic addrHit(
      input logic [amp_pkg::ADDR_W-1:0]               addr,
      input int                                       idx
   );
      return int'(addr) == idx;
   endfunction

   // register read with unmapped addresses reading zero
   function automatic logic [amp_pkg::DATA_W-1:0] regRead(
      input logic [NUM_REGS-1:0][amp_pkg::DATA_W-1:0] regs,
      input logic [amp_pkg::ADDR_W-1:0]               addr
   );
      logic [amp_pkg::DATA_W-1:0] val;
      val = '0;
      for (int i = 0; i < NUM_REGS; i++) begin
         if (addrHit(addr, i)) begin
            val = regs[i];
         end
      end
      return val;
   endfunction

   // register write; unmapped addresses leave every register unchanged
   function automatic logic [NUM_REGS-1:0][amp_pkg::DATA_W-1:0] regWrite(
      input logic [NUM_REGS-1:0][amp_pkg::DATA_W-1:0] regs,
      input logic [amp_pkg::ADDR_W-1:0]               addr,
      input logic [amp_pkg::DATA_W-1:0]               data
   );
      logic [NUM_REGS-1:0][amp_pkg::DATA_W-1:0] upd;
      upd = regs;
      for (int i = 0; i < NUM_REGS; i++) begin
         if (addrHit(addr, i)) begin
            upd[i] = data;
         end
      end
      return upd;
   endfunction

   // second synchroniser stages feed logic; the sck edge detects also use its third stage
   assign isSerial  = !q.strapS[1];
   assign csLevel   = q.csS[1];
   assign sckRise   = q.sckS[1] && !q.sckS[2];
   assign sckFall   = !q.sckS[1] && q.sckS[2];
   assign cmdByte   = {q.shift[6:0], q.sdiS[1]};
   assign frameWord = {q.shift[amp_pkg::FRAME_BITS-2:0], q.sdiS[1]};
   assign frameAddr = frameWord[amp_pkg::FRAME_BITS-2:amp_pkg::DATA_W];
   assign frameData = frameWord[amp_pkg::DATA_W-1:0];
   assign ctrlReg   = regRead(q.regs, amp_pkg::REG_CTRL);

   always_comb begin
      d        = q;
      // two-flop synchronisers on every pin, three flops on sck
      d.csS    = {q.csS[0], link.csN};
      d.sckS   = {q.sckS[1:0], link.sck};
      d.sdiS   = {q.sdiS[0], link.sdi};
      d.sdoS   = {q.sdoS[0], link.sdo};
      d.strapS = {q.strapS[0], link.strap};

      if (!isSerial || csLevel) begin
         // frame ends or never starts; nothing of a partial frame is kept
         d.state    = amp_pkg::D_IDLE;
         d.bitCnt   = '0;
         d.rdMode   = 1'b0;
         d.sdoDrive = 1'b0;
         d.shift    = '0;
         d.rdSh     = '0;
      end else begin
         case (q.state)
            amp_pkg::D_IDLE: begin
               d.state  = amp_pkg::D_SHIFT;
               d.bitCnt = '0;
            end

            amp_pkg::D_SHIFT: begin
               if (sckRise) begin
                  d.shift  = frameWord;
                  d.bitCnt = q.bitCnt + 5'h01;
                  // readback byte fetched once the command byte is in
                  if (q.bitCnt == amp_pkg::CNT_CMD_LAST) begin
                     d.rdMode = cmdByte[amp_pkg::DATA_W-1];
                     d.rdSh   = regRead(q.regs, cmdByte[amp_pkg::ADDR_W-1:0]);
                  end
                  if (q.bitCnt == amp_pkg::CNT_FRAME_LAST) begin
                     d.state = amp_pkg::D_DONE;
                     // registers change only when a whole write frame is in
                     if (!q.rdMode) begin
                        d.regs = regWrite(q.regs, frameAddr, frameData);
                     end
                  end
               end else if (sckFall && q.rdMode && q.bitCnt >= amp_pkg::CNT_DRV_FIRST) begin
                  // next bit goes out on the falling edge, pull-low only
                  d.sdoDrive = !q.rdSh[amp_pkg::DATA_W-1];
                  d.rdSh     = {q.rdSh[amp_pkg::DATA_W-2:0], 1'b0};
               end
            end

            amp_pkg::D_DONE: begin
               // extra clocks after a full frame are ignored
               if (sckFall) begin
                  d.sdoDrive = 1'b0;
               end
            end

            default: begin
               d.state = amp_pkg::D_IDLE;
            end
         endcase
      end

      // mode levels from the control register, or from the synchronised pins
      if (isSerial) begin
         d.pd   = ctrlReg[amp_pkg::CTRL_PD_BIT];
         d.one  = ctrlReg[amp_pkg::CTRL_ONE_BIT];
         d.half = ctrlReg[amp_pkg::CTRL_HALF_BIT];
         d.term = ctrlReg[amp_pkg::CTRL_TERM_BIT];
      end else begin
         d.one  = q.csS[1];
         d.half = q.sckS[1];
         d.pd   = q.sdiS[1];
         d.term = q.sdoS[1];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         q        <= '0;
         q.csS    <= 2'h3;
         q.state  <= amp_pkg::D_IDLE;
         for (int i = 0; i < NUM_REGS; i++) begin
            q.regs[i] <= amp_pkg::REG_RESET;
         end
      end else if (ce) begin
         q <= d;
      end
   end

   // pin becomes a pure input whenever the strap selects static levels
   assign link.devSdoOut = 1'b0;
   assign link.devSdoOe  = q.sdoDrive && isSerial;

   assign serialMode  = isSerial;
   assign powerDown   = q.pd;
   assign oneLane     = q.one;
   assign laneBEnable = !q.one;
   assign halfCurrent = q.half;
   assign termEnable  = q.term;
   assign regFile     = q.regs;

endmodule // amp_dev

// file: core/amp_host.sv
// host controller end of the mode programming port
`timescale 1ns/100ps
module amp_host (
   input  wire logic                  clk_sys,
   input  wire logic                  rst,
   input  wire logic                  ce,
   amp_if.host                        link,
   input  wire logic [3:0]            regAddr,
   input  wire logic [15:0]           regWdata,
   input  wire logic                  regWr,
   input  wire logic                  regRd,
   output logic [15:0]                regRdata,
   output logic                       busy
);

   typedef struct packed {
      amp_pkg::amp_hst_type           state;
      logic [amp_pkg::DIV_W-1:0]      div;
      logic [4:0]                     bitCnt;
      logic [amp_pkg::FRAME_BITS-1:0] frame;
      logic [amp_pkg::DATA_W-1:0]     rx;
      logic [amp_pkg::DATA_W-1:0]     rxLast;
      logic                           done;
      logic                           csN;
      logic                           sck;
      logic                           sdi;
      logic [4:0]                     par;
      logic [1:0]                     sdoS;
      logic [15:0]                    rdData;
   } amp_hstate_type;

   amp_hstate_type                    q;
   amp_hstate_type                    d;
   logic                              halfDone;
   logic                              setupDone;
   logic                              parEn;

   localparam logic [amp_pkg::DIV_W-1:0] HALF_LAST  = amp_pkg::DIV_W'(amp_pkg::SCK_HALF_CYC - 1);
   localparam logic [amp_pkg::DIV_W-1:0] SETUP_LAST = amp_pkg::DIV_W'(amp_pkg::CS_SETUP_CYC - 1);

   assign halfDone  = (q.div == HALF_LAST);
   assign setupDone = (q.div >= SETUP_LAST) && halfDone;
   assign parEn     = q.par[amp_pkg::PAR_EN_BIT];

   always_comb begin
      d        = q;
      d.sdoS   = {q.sdoS[0], link.sdo};
      d.rdData = '0;
      d.div    = halfDone ? '0 : q.div + 1'b1;

      if (regRd) begin
         case (regAddr)
            amp_pkg::HOST_STAT:  d.rdData = {14'h0000, q.done, q.state != amp_pkg::H_IDLE};
            amp_pkg::HOST_RDATA: d.rdData = {8'h00, q.rxLast};
            amp_pkg::HOST_PAR:   d.rdData = {11'h000, q.par};
            default:             d.rdData = '0;
         endcase
      end

      if (regWr) begin
         case (regAddr)
            amp_pkg::HOST_CMD: begin
               // refused while a frame runs or static levels are driven
               if (q.state == amp_pkg::H_IDLE && !parEn) begin
                  d.frame  = regWdata;
                  d.state  = amp_pkg::H_SETUP;
                  d.csN    = 1'b0;
                  d.sdi    = regWdata[amp_pkg::FRAME_BITS-1];
                  d.div    = '0;
                  d.bitCnt = '0;
               end
            end
            amp_pkg::HOST_STAT: begin
               if (regWdata[amp_pkg::STAT_DONE_BIT]) begin
                  d.done = 1'b0;
               end
            end
            amp_pkg::HOST_PAR: begin
               if (q.state == amp_pkg::H_IDLE) begin
                  d.par = regWdata[4:0];
               end
            end
            default: begin
               d.done = q.done;
            end
         endcase
      end

      // engine after the bus so a completing frame wins over a clear
      case (q.state)
         amp_pkg::H_IDLE: begin
            // a start taken above keeps its chip select low
            if (!(regWr && regAddr == amp_pkg::HOST_CMD && !parEn)) begin
               d.csN = 1'b1;
               d.sck = 1'b0;
            end
         end
         amp_pkg::H_SETUP: begin
            if (setupDone) begin
               d.sck    = 1'b1;
               d.bitCnt = q.bitCnt + 5'h01;
               d.state  = amp_pkg::H_HIGH;
            end
         end
         amp_pkg::H_HIGH: begin
            if (halfDone) begin
               d.sck = 1'b0;
               if (q.bitCnt >= amp_pkg::CNT_SMP_FIRST) begin
                  d.rx = {q.rx[amp_pkg::DATA_W-2:0], q.sdoS[1]};
               end
               d.frame = {q.frame[amp_pkg::FRAME_BITS-2:0], 1'b0};
               d.sdi   = q.frame[amp_pkg::FRAME_BITS-2];
               d.state = (q.bitCnt == amp_pkg::CNT_FRAME_END) ? amp_pkg::H_HOLD : amp_pkg::H_LOW;
            end
         end
         amp_pkg::H_LOW: begin
            if (halfDone) begin
               d.sck    = 1'b1;
               d.bitCnt = q.bitCnt + 5'h01;
               d.state  = amp_pkg::H_HIGH;
            end
         end
         amp_pkg::H_HOLD: begin
            if (halfDone) begin
               d.csN    = 1'b1;
               d.state  = amp_pkg::H_IDLE;
               d.done   = 1'b1;
               d.rxLast = q.rx;
            end
         end
         default: begin
            d.state = amp_pkg::H_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         q       <= '0;
         q.state <= amp_pkg::H_IDLE;
         q.csN   <= 1'b1;
      end else if (ce) begin
         q <= d;
      end
   end

   // static level mode drives all four pins, sdo included
   assign link.csN        = parEn ? q.par[0] : q.csN;
   assign link.sck        = parEn ? q.par[1] : q.sck;
   assign link.sdi        = parEn ? q.par[2] : q.sdi;
   assign link.hostSdoOut = q.par[3];
   assign link.hostSdoOe  = parEn;
   assign regRdata        = q.rdData;
   assign busy            = q.state != amp_pkg::H_IDLE;

endmodule // amp_host

// file: verif/amp_chk.sv
// pin-level assertions on the link between host and converter ends
`timescale 1ns/100ps
module amp_chk (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic csN,
   input wire logic sck,
   input wire logic sdi,
   input wire logic strap,
   input wire logic devSdoOut,
   input wire logic devSdoOe
);
   logic       sckQ;
   logic [4:0] bitCnt;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   // clock rises seen inside the current frame
   always_ff @(posedge clk_sys) begin
      sckQ <= sck;
      if (rst || csN) begin
         bitCnt <= 5'h00;
      end else if (sck && !sckQ) begin
         bitCnt <= bitCnt + 5'h01;
      end
   end

   a_sdo_pull_only: assert property (devSdoOe |-> !devSdoOut && !csN && bitCnt >= 5'h08)
      else $error("readback pin driven outside the data half");
   a_sdo_released: assert property (csN [*4] |-> !devSdoOe)
      else $error("readback pin held outside a frame");
   a_par_quiet: assert property (strap [*4] |-> !devSdoOe)
      else $error("readback pin driven in parallel mode");
   a_sck_idle: assert property ((!strap && csN) |-> !sck)
      else $error("link clock runs without chip select");
   a_cs_setup: assert property ((!strap && $rose(sck)) |-> !csN && !$past(csN))
      else $error("chip select setup too short");
   a_sck_high: assert property ((!strap && $rose(sck)) |-> sck [*3])
      else $error("link clock high phase too short");
   a_sck_low: assert property ((!strap && $fell(sck)) |-> !sck [*3])
      else $error("link clock low phase too short");
   a_sdi_hold: assert property ((!strap && sck && $past(sck)) |-> $stable(sdi))
      else $error("data in moved while clock high");
   a_frame_len: assert property ((!strap && $rose(csN)) |-> bitCnt == 5'h10)
      else $error("frame not sixteen bits");
   a_cs_gap: assert property ((!strap && $rose(csN)) |-> csN [*3])
      else $error("gap between frames too short");
   a_oe_in_low: assert property ($changed(devSdoOe) |-> !sck)
      else $error("readback bit changed while clock high");

   cover property (!csN && devSdoOe);
   cover property ($rose(csN) && bitCnt == 5'h10);
   cover property (strap && !csN);
endmodule // amp_chk

// file: verif/adc_mode_programming_port_tb_top.sv
// bench: host and converter joined, second converter bit-banged by the bench
`timescale 1ns/100ps
module adc_mode_programming_port_tb_top;
   logic            clk_sys = 1'b0;
   logic            rst = 1'b1;
   logic [3:0]      regAddr = 4'h0;
   logic [15:0]     regWdata = 16'h0000;
   logic            regWr = 1'b0;
   logic            regRd = 1'b0;
   logic [15:0]     regRdata;
   logic            busy;
   logic            serialMode, powerDown, oneLane, laneBEnable, halfCurrent, termEnable;
   logic [4:0][7:0] regFile, regFile2;
   logic [15:0]     q;
   int              err_count = 0;
   int              n_checks = 0;

   amp_if lnk ();
   amp_if lnk2 ();

   always #20 clk_sys = ~clk_sys;

   amp_host u_amp_host (.clk_sys(clk_sys), .rst(rst), .ce(1'b1), .link(lnk.host),
      .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
      .regRdata(regRdata), .busy(busy));
   amp_dev #(.NUM_REGS(5)) u_amp_dev (.clk_sys(clk_sys), .rst(rst), .ce(1'b1),
      .link(lnk.dev), .serialMode(serialMode), .powerDown(powerDown), .oneLane(oneLane),
      .laneBEnable(laneBEnable), .halfCurrent(halfCurrent), .termEnable(termEnable),
      .regFile(regFile));
   amp_dev #(.NUM_REGS(5)) u_amp_dev2 (.clk_sys(clk_sys), .rst(rst), .ce(1'b1),
      .link(lnk2.dev), .serialMode(), .powerDown(), .oneLane(), .laneBEnable(),
      .halfCurrent(), .termEnable(), .regFile(regFile2));
   amp_chk u_amp_chk (.clk_sys(clk_sys), .rst(rst), .csN(lnk.csN), .sck(lnk.sck),
      .sdi(lnk.sdi), .strap(lnk.strap), .devSdoOut(lnk.devSdoOut), .devSdoOe(lnk.devSdoOe));

   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
      n_checks++;
      if (s !== e) begin
         $display("Error %s expected %h seen %h", n, e, s);
         err_count++;
      end
   endtask

   // order: serial, power down, one lane, half current, termination, lane b
   task automatic modes(input logic [15:0] e);
      chk("modes", e, {10'h000, serialMode, powerDown, oneLane, halfCurrent, termEnable,
         laneBEnable});
   endtask

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge clk_sys);
      regWr <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a);
      @(posedge clk_sys);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk_sys);
      regRd <= 1'b0;
      #1 q = regRdata;
   endtask

   task automatic frame(input logic [15:0] w);
      int i;
      wr(amp_pkg::HOST_CMD, w);
      #1;
      chk("busy", 16'h0001, {15'h0000, busy});
      for (i = 0; i < 400 && busy !== 1'b0; i++) begin
         @(posedge clk_sys);
         #1;
      end
      if (busy !== 1'b0) begin
         chk("idle", 16'h0000, {15'h0000, busy});
         end_sim();
      end
      repeat (4) @(posedge clk_sys);
   endtask

   // n bits msb first at a 320 ns link clock; cs high sends stray clocks
   task automatic bang(input logic [15:0] w, input int n, input logic cs);
      int i;
      lnk2.csN <= cs;
      repeat (2) @(posedge clk_sys);
      for (i = 15; i > 15 - n; i--) begin
         lnk2.sdi <= w[i];
         repeat (4) @(posedge clk_sys);
         lnk2.sck <= 1'b1;
         repeat (4) @(posedge clk_sys);
         lnk2.sck <= 1'b0;
      end
      repeat (4) @(posedge clk_sys);
      lnk2.csN <= 1'b1;
      lnk2.sdi <= ~lnk2.sdi;
      repeat (6) @(posedge clk_sys);
   endtask

   task automatic t_serial();
      modes(16'h0021);
      frame(16'h000E);
      modes(16'h002E);
      rd(amp_pkg::HOST_STAT);
      chk("stat", 16'h0002, q);
      wr(amp_pkg::HOST_STAT, 16'h0002);
      rd(amp_pkg::HOST_STAT);
      chk("stat", 16'h0000, q);
      frame(16'h04A5);
      chk("reg4", 16'h00A5, {8'h00, regFile[4]});
      frame(16'h8400);
      rd(amp_pkg::HOST_RDATA);
      chk("rdata", 16'h00A5, {8'h00, q[7:0]});
      frame(16'h8000);
      rd(amp_pkg::HOST_RDATA);
      chk("rdata", 16'h000E, {8'h00, q[7:0]});
      frame(16'h0533);
      frame(16'h8500);
      rd(amp_pkg::HOST_RDATA);
      chk("rdata", 16'h0000, {8'h00, q[7:0]});
      $display("test serial done");
   endtask

   task automatic t_parallel();
      lnk.strap <= 1'b1;
      repeat (5) @(posedge clk_sys);
      wr(amp_pkg::HOST_PAR, 16'h001F);
      repeat (5) @(posedge clk_sys);
      modes(16'h001E);
      wr(amp_pkg::HOST_PAR, 16'h0010);
      repeat (5) @(posedge clk_sys);
      modes(16'h0001);
      rd(amp_pkg::HOST_PAR);
      chk("par", 16'h0010, q);
      wr(amp_pkg::HOST_PAR, 16'h0000);
      repeat (2) @(posedge clk_sys);
      lnk.strap <= 1'b0;
      repeat (5) @(posedge clk_sys);
      modes(16'h002E);
      $display("test parallel done");
   endtask

   task automatic t_fault();
      bang(16'h00FF, 16, 1'b1);
      chk("stray", 16'h0000, {8'h00, regFile2[0]});
      bang(16'h00FF, 10, 1'b0);
      chk("partial", 16'h0000, {8'h00, regFile2[0]});
      bang(16'h0003, 16, 1'b0);
      chk("full", 16'h0003, {8'h00, regFile2[0]});
      $display("test fault done");
   endtask

   initial begin
      lnk.strap = 1'b0;
      lnk2.csN = 1'b1;
      lnk2.sck = 1'b0;
      lnk2.sdi = 1'b0;
      lnk2.strap = 1'b0;
      lnk2.hostSdoOut = 1'b0;
      lnk2.hostSdoOe = 1'b0;
      repeat (12) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (4) @(posedge clk_sys);
      t_serial();
      t_parallel();
      t_fault();
      end_sim();
   end
endmodule // adc_mode_programming_port_tb_top
